// ---- design/fss_map.svh ----
// Purpose: Register offsets, reset values and timing counts of the sequencer
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH

// Register byte offsets
`define FSS_OFF_CTRL 8'h00
`define FSS_OFF_STATUS 8'h04
`define FSS_OFF_INT_STATUS 8'h08
`define FSS_OFF_INT_CLEAR 8'h0C
`define FSS_OFF_INT_ENABLE 8'h10

// Reset values
`define FSS_RST_CTRL 1'h1
`define FSS_RST_INT_ENABLE 8'h00

// Control field position
`define FSS_CTRL_ENABLE_BIT 0

// Status field positions
`define FSS_ST_STATE_LSB 0
`define FSS_ST_STARTUP_BIT 2
`define FSS_ST_CC_BIT 3
`define FSS_ST_GATE_BIT 4
`define FSS_ST_CYCLE_LSB 5
`define FSS_ST_CAUSE_LSB 8

// Interrupt event bit positions
`define FSS_EV_OVERVOLT 0
`define FSS_EV_LINE_UV 1
`define FSS_EV_CS_HIGH 2
`define FSS_EV_CS_SHORT 3
`define FSS_EV_OVERTEMP 4
`define FSS_EV_FB_LOST 5
`define FSS_EV_SUPPLY_UNDERVOLTAGE_LOCKOUT_STOP 6
`define FSS_EV_RUN_START 7

// Sequencing counts
`define FSS_START_CYCLES 3'h4
`define FSS_FAULT_REPEAT 2'h3

// Timing
`define FSS_CLK_MHZ 200
`define FSS_CS_SHORT_NS 4000

`endif

// ---- design/fss_pkg.sv ----
// Purpose: Types shared by the flyback start-up and fault sequencer
// Assumes: Constants live in fss_map.svh
// Notes: Nothing here is imported; users write fss_pkg::name
package fss_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        FSS_ST_START = 2'b00,
        FSS_ST_RUN = 2'b01,
        FSS_ST_FAULT = 2'b10
    } fss_state_type;

    // Bias consumption levels
    typedef enum logic [1:0] {
        FSS_BIAS_START = 2'b00,
        FSS_BIAS_RUN = 2'b01,
        FSS_BIAS_WAIT = 2'b10,
        FSS_BIAS_FAULT = 2'b11
    } fss_bias_type;

    // Peak current level selection
    typedef enum logic [1:0] {
        FSS_PEAK_MIN = 2'b00,
        FSS_PEAK_STARTUP = 2'b01,
        FSS_PEAK_MAX = 2'b10
    } fss_peak_type;

    // Comparator and sensor flags, all asynchronous to pclk
    typedef struct packed {
        logic vdd_on;
        logic vdd_off;
        logic aux_low;
        logic aux_high;
        logic aux_ov;
        logic line_run;
        logic line_stop;
        logic cs_peak;
        logic cs_min;
        logic cs_high;
        logic temp_hot;
        logic fb_lost;
        logic cv_reg;
        logic ipp_high;
        logic cycle_req;
    } fss_flags_type;

endpackage

// ---- design/fss_sequencer.sv ----
// Purpose: Start-up, run/wait and fault sequencer of a flyback controller
// Assumes: Comparator flags arrive asynchronously; APB register access
// Notes: Control law, valley switching and analog sensing live elsewhere
`timescale 1ns/100ps
`include "fss_map.svh"

// Functional notes
// - Turn-on threshold enables switching, start source off
// - First four cycles use minimum peak
// - Low aux after four cycles enters startup
// - Aux above exit level restores normal limits
// - Constant current until output regulated
// - Three overvoltage cycles stop, fault bias
// - After turn-off, restart full sequence
// - Line current run and stop checks
// - On-time ends at cycle peak level
// - Three overcurrent cycles cause restart
// - Minimum level missed in 4us of the first cycle faults
// - Open sense pin at limit faults
// - Overtemperature repeats reset cycles
// - Feedback loss stops then restarts
// - Run bias above 0.55, else wait
// - Turn-off stops switching, start source on
// - Faults hold fault bias until turn-off
module fss_sequencer #(
    parameter int ON_MAX_CYCLES = 2000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator and sensor flags
    input wire fss_pkg::fss_flags_type flags_in,
    // Power stage controls
    output logic gate_drive,
    output logic hv_start_en,
    output fss_pkg::fss_bias_type bias_sel,
    output fss_pkg::fss_peak_type peak_sel,
    output logic demag_high,
    output logic cc_mode,
    // Interrupt
    output logic irq
);

    localparam int FLAG_W = $bits(fss_pkg::fss_flags_type);
    localparam int CS_SHORT_CYC = `FSS_CS_SHORT_NS * `FSS_CLK_MHZ / 1000;
    localparam logic [11:0] CS_SHORT_LAST = 12'(CS_SHORT_CYC - 1);
    localparam logic [11:0] ON_MAX_LAST = 12'(ON_MAX_CYCLES - 1);

    logic [FLAG_W-1:0] sync1;
    logic [FLAG_W-1:0] sync2;
    logic [FLAG_W-1:0] sync3;
    logic [FLAG_W-1:0] filt;
    fss_pkg::fss_flags_type f;
    fss_pkg::fss_state_type state;
    fss_pkg::fss_state_type next_state;
    logic next_gate;
    logic cyc_end;
    logic [11:0] on_count;
    logic [2:0] cycle_count;
    logic first_cycle;
    logic startup_mode;
    logic [1:0] ov_cnt;
    logic [1:0] cs_cnt;
    logic cs_min_seen;
    logic line_seen;
    logic [5:0] fault_hit;
    logic [5:0] last_cause;
    logic ctrl_enable;
    logic [7:0] int_status;
    logic [7:0] int_enable;
    logic [7:0] events;
    logic [7:0] int_clear;
    logic apb_setup;
    logic apb_write;
    logic [31:0] rd_mux;
    logic rd_hit;

    // three-stage flag sync
    // Only stage two reads stage one; a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt <= '0;
        end else begin
            sync1 <= flags_in;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
        end
    end
    assign f = fss_pkg::fss_flags_type'(filt);

    assign first_cycle = (cycle_count == 3'h0);

    // on-time ends at cycle peak
    // The max on-time bound only keeps a stuck comparator from latching the gate
    assign cyc_end = gate_drive && (f.cs_peak || on_count == ON_MAX_LAST);

    // Fault detection while running
    always_comb begin
        fault_hit = '0;
        fault_hit[`FSS_EV_OVERVOLT] = cyc_end && f.aux_ov && ov_cnt == (`FSS_FAULT_REPEAT - 2'h1);
        fault_hit[`FSS_EV_LINE_UV] = (gate_drive && f.line_stop)
            || (cyc_end && first_cycle && !(line_seen || f.line_run));
        fault_hit[`FSS_EV_CS_HIGH] = cyc_end && f.cs_high && cs_cnt == (`FSS_FAULT_REPEAT - 2'h1);
        fault_hit[`FSS_EV_CS_SHORT] = gate_drive && first_cycle && !cs_min_seen && !f.cs_min
            && on_count == CS_SHORT_LAST;
        fault_hit[`FSS_EV_OVERTEMP] = f.temp_hot;
        fault_hit[`FSS_EV_FB_LOST] = f.fb_lost;
    end

    // Next state; supply turn-off wins over any fault
    always_comb begin
        next_state = state;
        case (state)
            fss_pkg::FSS_ST_START: begin
                if (f.vdd_on && !f.vdd_off && ctrl_enable) begin
                    next_state = fss_pkg::FSS_ST_RUN;
                end
            end
            fss_pkg::FSS_ST_RUN: begin
                if (f.vdd_off) begin
                    next_state = fss_pkg::FSS_ST_START;
                end else if (|fault_hit) begin
                    next_state = fss_pkg::FSS_ST_FAULT;
                end
            end
            fss_pkg::FSS_ST_FAULT: begin
                if (f.vdd_off) begin
                    next_state = fss_pkg::FSS_ST_START;
                end
            end
            default: begin
                next_state = fss_pkg::FSS_ST_START;
            end
        endcase
    end

    // Gate request: only in run, one cycle per modulator request
    always_comb begin
        if (next_state != fss_pkg::FSS_ST_RUN) begin
            next_gate = 1'b0;
        end else if (gate_drive) begin
            next_gate = !cyc_end;
        end else begin
            next_gate = f.cycle_req;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= fss_pkg::FSS_ST_START;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_drive <= 1'b0;
            on_count <= 12'h000;
        end else begin
            gate_drive <= next_gate;
            on_count <= (gate_drive && next_gate) ? on_count + 12'h001 : 12'h000;
        end
    end

    // Per-cycle observations of the sense pin and line current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_min_seen <= 1'b0;
            line_seen <= 1'b0;
        end else if (!gate_drive) begin
            cs_min_seen <= 1'b0;
            line_seen <= 1'b0;
        end else begin
            cs_min_seen <= cs_min_seen | f.cs_min;
            line_seen <= line_seen | f.line_run;
        end
    end

    // counters clear on miss and restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_cnt <= 2'h0;
            cs_cnt <= 2'h0;
            cycle_count <= 3'h0;
        end else if (state != fss_pkg::FSS_ST_RUN) begin
            ov_cnt <= 2'h0;
            cs_cnt <= 2'h0;
            cycle_count <= 3'h0;
        end else if (cyc_end) begin
            ov_cnt <= f.aux_ov ? ov_cnt + 2'h1 : 2'h0;
            cs_cnt <= f.cs_high ? cs_cnt + 2'h1 : 2'h0;
            if (cycle_count != `FSS_START_CYCLES) begin
                cycle_count <= cycle_count + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_mode <= 1'b0;
        end else if (state != fss_pkg::FSS_ST_RUN) begin
            startup_mode <= 1'b0;
        end else if (cyc_end && cycle_count == (`FSS_START_CYCLES - 3'h1) && f.aux_low) begin
            startup_mode <= 1'b1;
        end else if (cyc_end && f.aux_high) begin
            startup_mode <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_mode <= 1'b0;
        end else if (state == fss_pkg::FSS_ST_START && next_state == fss_pkg::FSS_ST_RUN) begin
            cc_mode <= 1'b1;
        end else if (state != fss_pkg::FSS_ST_RUN || f.cv_reg) begin
            cc_mode <= 1'b0;
        end
    end

    // minimum peak first cycles
    // Peak limit follows the cycle count and startup mode, demag limit the startup mode, one clock later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peak_sel <= fss_pkg::FSS_PEAK_MIN;
            demag_high <= 1'b0;
        end else begin
            if (cycle_count != `FSS_START_CYCLES) begin
                peak_sel <= fss_pkg::FSS_PEAK_MIN;
            end else if (startup_mode) begin
                peak_sel <= fss_pkg::FSS_PEAK_STARTUP;
            end else begin
                peak_sel <= fss_pkg::FSS_PEAK_MAX;
            end
            demag_high <= startup_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_sel <= fss_pkg::FSS_BIAS_START;
            hv_start_en <= 1'b1;
        end else begin
            hv_start_en <= (next_state == fss_pkg::FSS_ST_START);
            case (next_state)
                fss_pkg::FSS_ST_RUN: begin
                    bias_sel <= (next_gate || f.ipp_high || cc_mode) ? fss_pkg::FSS_BIAS_RUN
                                                                    : fss_pkg::FSS_BIAS_WAIT;
                end
                fss_pkg::FSS_ST_FAULT: begin
                    bias_sel <= fss_pkg::FSS_BIAS_FAULT;
                end
                default: begin
                    bias_sel <= fss_pkg::FSS_BIAS_START;
                end
            endcase
        end
    end

    // Last fault cause, kept for software after the restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cause <= 6'h00;
        end else if (state == fss_pkg::FSS_ST_RUN && next_state == fss_pkg::FSS_ST_FAULT) begin
            last_cause <= fault_hit;
        end
    end

    // Interrupt events: one pulse per transition
    always_comb begin
        events = '0;
        if (state == fss_pkg::FSS_ST_RUN && next_state == fss_pkg::FSS_ST_FAULT) begin
            events[5:0] = fault_hit;
        end
        events[`FSS_EV_SUPPLY_UNDERVOLTAGE_LOCKOUT_STOP] = state == fss_pkg::FSS_ST_RUN && f.vdd_off;
        events[`FSS_EV_RUN_START] = state == fss_pkg::FSS_ST_START
            && next_state == fss_pkg::FSS_ST_RUN;
    end

    // APB decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;
    assign int_clear = (apb_write && paddr == `FSS_OFF_INT_CLEAR) ? pwdata[7:0] : 8'h00;

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 8'h00;
        end else begin
            int_status <= (int_status & ~int_clear) | events;
        end
    end

    // Writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enable <= `FSS_RST_CTRL;
            int_enable <= `FSS_RST_INT_ENABLE;
        end else if (apb_write) begin
            if (paddr == `FSS_OFF_CTRL) begin
                ctrl_enable <= pwdata[`FSS_CTRL_ENABLE_BIT];
            end
            if (paddr == `FSS_OFF_INT_ENABLE) begin
                int_enable <= pwdata[7:0];
            end
        end
    end

    // Level interrupt, one clock behind the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_enable);
        end
    end

    // Read mux; unmapped addresses answer with an error and zero data
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `FSS_OFF_CTRL: rd_mux[`FSS_CTRL_ENABLE_BIT] = ctrl_enable;
            `FSS_OFF_STATUS: begin
                rd_mux[`FSS_ST_STATE_LSB +: 2] = state;
                rd_mux[`FSS_ST_STARTUP_BIT] = startup_mode;
                rd_mux[`FSS_ST_CC_BIT] = cc_mode;
                rd_mux[`FSS_ST_GATE_BIT] = gate_drive;
                rd_mux[`FSS_ST_CYCLE_LSB +: 3] = cycle_count;
                rd_mux[`FSS_ST_CAUSE_LSB +: 6] = last_cause;
            end
            `FSS_OFF_INT_STATUS: rd_mux[7:0] = int_status;
            `FSS_OFF_INT_CLEAR: rd_mux = 32'h0000_0000;
            `FSS_OFF_INT_ENABLE: rd_mux[7:0] = int_enable;
            default: rd_hit = 1'b0;
        endcase
    end

    // One wait-free access phase: answer prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= !rd_hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_gate_outside_run: assert property (
        (state != fss_pkg::FSS_ST_RUN) |-> !gate_drive)
        else $error("gate driven outside run state");
    a_hv_off_running: assert property (
        (state == fss_pkg::FSS_ST_RUN) |-> (!hv_start_en && bias_sel != fss_pkg::FSS_BIAS_START))
        else $error("start source or start bias while running");
    a_min_peak_start: assert property (
        (gate_drive && $past(gate_drive) && cycle_count < `FSS_START_CYCLES)
        |-> peak_sel == fss_pkg::FSS_PEAK_MIN)
        else $error("peak not minimum in first cycles");
    a_startup_entry: assert property (
        (state == fss_pkg::FSS_ST_RUN && !f.vdd_off && fault_hit == 6'h00 && cyc_end
         && cycle_count == 3'h3 && f.aux_low) |=> startup_mode ##1 demag_high)
        else $error("startup mode not entered");
    a_startup_exit: assert property (
        (startup_mode && cyc_end && f.aux_high && !f.vdd_off && fault_hit == 6'h00)
        |=> !startup_mode ##1 (!demag_high && peak_sel == fss_pkg::FSS_PEAK_MAX))
        else $error("startup mode not left");
    a_overvolt_stop: assert property (
        (state == fss_pkg::FSS_ST_RUN && !f.vdd_off && fault_hit[`FSS_EV_OVERVOLT])
        |=> (state == fss_pkg::FSS_ST_FAULT && bias_sel == fss_pkg::FSS_BIAS_FAULT))
        else $error("overvoltage did not stop switching");
    a_fault_restart: assert property (
        (state == fss_pkg::FSS_ST_FAULT && f.vdd_off)
        |=> (state == fss_pkg::FSS_ST_START && hv_start_en))
        else $error("fault did not return to start");
    a_cycle_end: assert property (
        (gate_drive && f.cs_peak) |=> !gate_drive)
        else $error("on-time not ended at peak");
    a_cs_short: assert property (
        (state == fss_pkg::FSS_ST_RUN && !f.vdd_off && fault_hit[`FSS_EV_CS_SHORT])
        |=> state == fss_pkg::FSS_ST_FAULT)
        else $error("shorted sense pin not faulted");
    a_overtemp: assert property (
        (state == fss_pkg::FSS_ST_RUN && !f.vdd_off && f.temp_hot)
        |=> state == fss_pkg::FSS_ST_FAULT)
        else $error("overtemperature not faulted");
    a_supply_undervoltage_lockout_stop: assert property (
        (state == fss_pkg::FSS_ST_RUN && f.vdd_off)
        |=> (state == fss_pkg::FSS_ST_START && !gate_drive && hv_start_en))
        else $error("turn-off did not stop switching");
    a_counter_clear: assert property (
        (state == fss_pkg::FSS_ST_RUN && cyc_end && !f.aux_ov) |=> ov_cnt == 2'h0)
        else $error("overvoltage counter not cleared");

    c_run_reached: cover property (state == fss_pkg::FSS_ST_START ##1 state == fss_pkg::FSS_ST_RUN);
    c_startup_mode: cover property ($rose(startup_mode));
    c_fault_cycle: cover property (state == fss_pkg::FSS_ST_FAULT ##1 state == fss_pkg::FSS_ST_START);
    c_wait_bias: cover property (bias_sel == fss_pkg::FSS_BIAS_WAIT);

endmodule // fss_sequencer

// ---- test/fss_stage_model.sv ----
// Purpose: Behavioural flyback stage facing the sequencer
// Assumes: Bench sets the static comparator levels through env
// Notes: Sense ramp length comes from on_len; a cycle is asked for after a rest
`timescale 1ns/100ps
module fss_stage_model (
    // Clock
    input wire logic pclk,
    // Bench knobs
    input wire fss_pkg::fss_flags_type env,
    input wire logic [3:0] on_len,
    // Controller side
    input wire logic gate_drive,
    output fss_pkg::fss_flags_type flags
);
    logic [3:0] on_cnt = 4'h0;
    logic [3:0] off_cnt = 4'h0;

    // Ramp and rest counters
    always_ff @(posedge pclk) begin
        on_cnt <= gate_drive ? on_cnt + 4'h1 : 4'h0;
        off_cnt <= gate_drive ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hF};
    end

    // Flags follow the switch; a shorted sense pin never ramps
    always_comb begin
        flags = env;
        flags.cs_peak = env.cs_min & gate_drive & (on_cnt >= on_len);
        flags.cs_min = flags.cs_peak;
        flags.line_run = env.line_run & gate_drive; // Line current only seen in on-time
        flags.cycle_req = env.cycle_req & ~gate_drive & (off_cnt == 4'hF);
    end
endmodule // fss_stage_model

// ---- test/tb_flyback_startup_fault_sequencer.sv ----
// Purpose: Self-checking bench for the start-up and fault sequencer
// Assumes: Stage model answers every gate pulse
// Notes: ON_MAX_CYCLES shortened to keep the run brief
`timescale 1ns/100ps
`include "fss_map.svh"
module tb_flyback_startup_fault_sequencer;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, gate_drive, hv_start_en, demag_high, cc_mode, irq, err;
    logic [3:0] on_len = 4'h4;
    logic [31:0] rd;
    logic [14:0] fmask [6] = '{15'h0400, 15'h0100, 15'h0020, 15'h0040, 15'h0010, 15'h0008};
    fss_pkg::fss_bias_type bias_sel;
    fss_pkg::fss_peak_type peak_sel;
    fss_pkg::fss_flags_type flags;
    fss_pkg::fss_flags_type env = '0;
    int mismatches = 0;
    int n_compared = 0;

    // Clock, 5 ns period
    always #2.5 pclk = ~pclk;

    fss_sequencer #(.ON_MAX_CYCLES(1000)) i_fss_sequencer (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags_in(flags),
        .gate_drive(gate_drive), .hv_start_en(hv_start_en), .bias_sel(bias_sel),
        .peak_sel(peak_sel), .demag_high(demag_high), .cc_mode(cc_mode), .irq(irq));

    fss_stage_model i_fss_stage_model (.pclk(pclk), .env(env), .on_len(on_len),
        .gate_drive(gate_drive), .flags(flags));

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; an idle cycle after it keeps psel edges apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), exp, rd);
    endtask

    task automatic wait_bias(input fss_pkg::fss_bias_type b, input int lim);
        int n;
        n = 0;
        while (bias_sel !== b && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("bias", {30'h0, b}, {30'h0, bias_sel});
    endtask

    // Count switch-off edges, then let the cycle-end updates land
    task automatic falls(input int k);
        repeat (k) @(negedge gate_drive);
        tick(3);
    endtask

    // Rail to turn-off, then to turn-on
    task automatic restart;
        tick(1);
        env.vdd_on <= 1'b0;
        env.vdd_off <= 1'b1;
        tick(1); // Keeps each rail flag to one assignment per time step
        wait_bias(fss_pkg::FSS_BIAS_START, 100);
        chk("hv on", 32'h1, {31'h0, hv_start_en});
        env.vdd_off <= 1'b0;
        env.vdd_on <= 1'b1;
        tick(2);
        chk("hv sync", 32'h1, {31'h0, hv_start_en});
        tick(6);
        chk("hv off", 32'h0, {31'h0, hv_start_en});
    endtask

    // Main sequence
    initial begin
        tick(10);
        presetn <= 1'b1;
        tick(2);
        chk("gate", 32'h0, {31'h0, gate_drive});
        chk("hv", 32'h1, {31'h0, hv_start_en});
        rdchk(`FSS_OFF_CTRL, 32'h1);
        rdchk(`FSS_OFF_INT_ENABLE, 32'h0);
        rdchk(8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, `FSS_OFF_INT_ENABLE, 32'hFF);
        rdchk(`FSS_OFF_INT_ENABLE, 32'hFF);
        rdchk(`FSS_OFF_INT_CLEAR, 32'h0);
        // Line ok, sense ramps, heavy load, aux low
        env <= fss_pkg::fss_flags_type'(15'h1243);
        restart;
        chk("cc", 32'h1, {31'h0, cc_mode});
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, `FSS_OFF_INT_CLEAR, 32'hFF);
        tick(1); // Line follows status one clock later
        chk("irq clr", 32'h0, {31'h0, irq});
        falls(3);
        chk("peak", 32'h0, {30'h0, peak_sel});
        falls(1);
        chk("peak", 32'h1, {30'h0, peak_sel});
        chk("demag", 32'h1, {31'h0, demag_high});
        env.aux_low <= 1'b0;
        env.aux_high <= 1'b1;
        falls(1);
        chk("peak", 32'h2, {30'h0, peak_sel});
        chk("demag", 32'h0, {31'h0, demag_high});
        env.cv_reg <= 1'b1;
        env.ipp_high <= 1'b0;
        falls(2);
        chk("cc", 32'h0, {31'h0, cc_mode});
        chk("bias", 32'h2, {30'h0, bias_sel});
        env.ipp_high <= 1'b1;
        tick(6);
        chk("bias", 32'h1, {30'h0, bias_sel});
        // Two overvoltage cycles, a clean one, two more: no fault
        on_len <= 4'h9;
        repeat (2) begin
            env.aux_ov <= 1'b1;
            falls(2);
            env.aux_ov <= 1'b0;
            falls(1);
        end
        chk("bias", 32'h1, {30'h0, bias_sel});
        // One pass per fault kind, each from a fresh start-up
        for (int i = 0; i < 6; i++) begin
            env <= fss_pkg::fss_flags_type'(15'h0A47 ^ fmask[i]);
            restart;
            if (i == 0) chk("peak", 32'h0, {30'h0, peak_sel});
            wait_bias(fss_pkg::FSS_BIAS_FAULT, 3000);
            if (i == 4) restart;
            if (i == 4) wait_bias(fss_pkg::FSS_BIAS_FAULT, 100);
            chk("gate", 32'h0, {31'h0, gate_drive});
            apb(1'b0, `FSS_OFF_STATUS, 32'h0);
            chk("status", 32'h2 | (32'h100 << i), rd);
            apb(1'b0, `FSS_OFF_INT_STATUS, 32'h0);
            chk("events", 32'h80 | (32'h1 << i), rd & 32'hBF);
            chk("irq", 32'h1, {31'h0, irq});
            apb(1'b1, `FSS_OFF_INT_CLEAR, 32'hFF);
            tick(2);
            chk("irq clr", 32'h0, {31'h0, irq});
        end
        // Masked event keeps the line low but stays sticky
        apb(1'b1, `FSS_OFF_INT_ENABLE, 32'h0);
        env <= fss_pkg::fss_flags_type'(15'h0A47);
        restart;
        tick(4);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, `FSS_OFF_INT_STATUS, 32'h0);
        chk("run event", 32'h1, {31'h0, rd[7]});
        final_report;
    end

    // Watchdog, well beyond the expected run
    initial begin
        #150000;
        mismatches++;
        $display("[FAIL] watchdog expected finish seen timeout");
        final_report;
    end
endmodule // tb_flyback_startup_fault_sequencer
